// >>> logic/twep_defs.svh
// constants of the two-wire eeprom slave port
`ifndef TWEP_DEFS_SVH
`define TWEP_DEFS_SVH

// ==========================================================
// timing, in ns and at the system clock
`define TWEP_CLK_NS 4
`define TWEP_T_SPIKE_NS 50
`define TWEP_T_WR_NS 5000000

// ==========================================================
// bus framing
`define TWEP_DEV_CODE 4'ha
`define TWEP_BYTE_BITS 4'h8
`define TWEP_ACK_SLOT 4'h9
`define TWEP_BIT_FIRST 4'h1
`define TWEP_RW_BIT 0

// ==========================================================
// memory organisation
`define TWEP_ADDR_BITS 15
`define TWEP_PAGE_BITS 6
`define TWEP_DATA_BITS 8
`define TWEP_FIFO_BITS 17
`define TWEP_PAIR_BIT 16
`define TWEP_ERASED 8'hff

// ==========================================================
// reset values
`define TWEP_SYNC_RST 6'h03
`define TWEP_LINE_IDLE 1'b1
`endif

// >>> logic/twep_pkg.sv
// state types of the two-wire eeprom slave port
package twep_pkg;
    // bus side, gray along idle, device byte, address, data
    typedef enum logic [2:0] {
        TWEP_IDLE = 3'b000,
        TWEP_DEV = 3'b001,
        TWEP_AHI = 3'b011,
        TWEP_ALO = 3'b010,
        TWEP_WR = 3'b110,
        TWEP_RD = 3'b111,
        TWEP_IGN = 3'b101
    } twep_bus_e;
    // programming side
    typedef enum logic [1:0] {
        TWEP_P_IDLE = 2'b00,
        TWEP_P_DRAIN = 2'b01,
        TWEP_P_WAIT = 2'b11
    } twep_prog_e;
endpackage

// >>> logic/twep_mem.sv
// byte array of the eeprom with a registered read port
`timescale 1ns/1ps
`include "twep_defs.svh"
module twep_mem #(
    parameter int AW = `TWEP_ADDR_BITS,
    parameter int DW = `TWEP_DATA_BITS
) (
    input wire logic clock,
    input wire logic en,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);
    // cells hold the complement: a two-state array starts at zero,
    // so a fresh array reads as erased ones without a second writer
    bit [DW-1:0] mem_q [2**AW];

    // ======================================================
    // one write port for programming, one read port for the bus
    always_ff @(posedge clock) begin
        if (en) begin
            if (we) begin
                mem_q[waddr] <= ~wdata;
            end
            rdata <= ~mem_q[raddr];
        end
    end
endmodule

// >>> logic/twep_fifo.sv
// page buffer fifo between the bus and the programming cycle
`timescale 1ns/1ps
`include "twep_defs.svh"
module twep_fifo #(
    parameter int W = `TWEP_FIFO_BITS,
    parameter int DEPTH = 32
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
    localparam logic [PW:0] FULL = (PW + 1)'(DEPTH);

    logic [W-1:0] buf_q [DEPTH];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [PW:0] cnt_q;
    wire logic push;
    wire logic pop;

    // ======================================================
    // handshake terms; full and empty come from the count
    assign in_ready = cnt_q != FULL;
    assign out_valid = cnt_q != '0;
    assign out_data = buf_q[rd_q];
    assign push = en & in_valid & in_ready;
    assign pop = en & out_valid & out_ready;

    // storage, no reset needed since the count guards it
    always_ff @(posedge clock) begin
        if (push) begin
            buf_q[wr_q] <= in_data;
        end
    end

    // pointers wrap at the last slot so any depth works
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == LAST) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == LAST) ? '0 : rd_q + 1'b1;
            end
        end
    end

    // occupancy
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= '0;
        end else if (push & !pop) begin
            cnt_q <= cnt_q + 1'b1;
        end else if (pop & !push) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end
endmodule

// >>> logic/twep_slave.sv
// two-wire eeprom target: bus decoder, page buffer and write cycle
`timescale 1ns/1ps
`include "twep_defs.svh"
// Contract
// - data line sampled at each rising clock edge
// - read data changes only after a falling clock edge
// - data line only pulled low or released, never driven high
// - respond only when address bits equal the three strap inputs
// - undriven strap and lock inputs read as low
// - lock input high blocks every array write
// - lock input low lets writes proceed normally
// - array of 32768 bytes, fifteen-bit byte address
// - page writes up to 64 bytes, shorter pages accepted
// - self-timed programming after the write ends, within 5 ms
// - random reads and sequential streaming reads
// - short glitches on clock and data are filtered out
module twep_slave #(
    parameter int FILT_CYC = (`TWEP_T_SPIKE_NS + `TWEP_CLK_NS - 1) / `TWEP_CLK_NS,
    parameter int WR_CYC = `TWEP_T_WR_NS / `TWEP_CLK_NS,
    parameter int FIFO_DEPTH = 32
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic select_strap_bit0,
    input wire logic select_strap_bit1,
    input wire logic select_strap_bit2,
    input wire logic write_lock,
    output logic write_busy
);
    import twep_pkg::*;

    localparam int AW = `TWEP_ADDR_BITS;
    localparam int PB = `TWEP_PAGE_BITS;
    localparam int FCW = $clog2(FILT_CYC + 1);
    localparam int WCW = $clog2(WR_CYC + 1);
    localparam logic [FCW-1:0] FILT_LAST = FCW'(FILT_CYC - 1);
    localparam logic [WCW-1:0] WR_LAST = WCW'(WR_CYC - 1);

    // ======================================================
    // pin synchronisers and glitch filters
    logic [5:0] sync1_q;
    logic [5:0] sync2_q;
    wire logic [5:0] pins;
    wire logic [1:0] filt;
    logic [1:0] prev_q;
    wire logic [2:0] strap;
    wire logic lock;

    // pads pull undriven straps and lock low, so they arrive as 0
    assign pins = {write_lock, select_strap_bit2, select_strap_bit1,
                   select_strap_bit0, sda_i, scl};

    // two flops on every pin before anything reads it
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sync1_q <= `TWEP_SYNC_RST;
            sync2_q <= `TWEP_SYNC_RST;
        end else if (clk_en) begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
        end
    end
    assign strap = sync2_q[4:2];
    assign lock = sync2_q[5];

    // a level must hold for the spike time before it is believed
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_filt
            logic [FCW-1:0] cnt_q;
            logic lvl_q;
            always_ff @(posedge clock or negedge resetn) begin
                if (!resetn) begin
                    cnt_q <= '0;
                    lvl_q <= `TWEP_LINE_IDLE;
                end else if (clk_en) begin
                    if (sync2_q[g] == lvl_q) begin
                        cnt_q <= '0;
                    end else if (cnt_q == FILT_LAST) begin
                        cnt_q <= '0;
                        lvl_q <= sync2_q[g];
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
            end
            assign filt[g] = lvl_q;
        end
    endgenerate

    // previous filtered levels for edge detection
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            prev_q <= {`TWEP_LINE_IDLE, `TWEP_LINE_IDLE};
        end else if (clk_en) begin
            prev_q <= filt;
        end
    end

    // ======================================================
    // bus events
    wire logic scl_rise;
    wire logic scl_fall;
    wire logic sda_f;
    wire logic start;
    wire logic stop;

    // idle clock is high, so a data edge with clock high frames
    assign sda_f = filt[1];
    assign scl_rise = clk_en & filt[0] & !prev_q[0];
    assign scl_fall = clk_en & !filt[0] & prev_q[0];
    assign start = clk_en & filt[0] & prev_q[0] & !sda_f & prev_q[1];
    assign stop = clk_en & filt[0] & prev_q[0] & sda_f & !prev_q[1];

    // ======================================================
    // bus state
    twep_bus_e st_q;
    twep_bus_e nxt_q;
    twep_bus_e nxt_sel;
    twep_prog_e pst_q;
    logic [3:0] bit_q;
    logic [7:0] rx_q;
    logic [7:0] tx_q;
    logic [AW-1:0] addr_q;
    logic [AW-1:0] base_q;
    logic [6:0] ahi_q;
    logic [7:0] stage_q;
    logic stage_v_q;
    logic pend_q;
    logic oe_q;
    logic ack_sel;
    wire logic active;
    wire logic byte_end;
    wire logic ack_end;
    wire logic bit_fall;
    wire logic dev_hit;
    wire logic busy;
    wire logic wr_take;
    wire logic launch;
    wire logic [7:0] rdata;
    wire logic in_ready;
    wire logic push;
    wire logic flush;
    wire logic [`TWEP_FIFO_BITS-1:0] in_data;
    wire logic [AW-1:0] addr_page_inc;

    assign busy = pst_q != TWEP_P_IDLE;
    assign active = (st_q != TWEP_IDLE) & (st_q != TWEP_IGN);
    assign byte_end = scl_fall & active & (bit_q == `TWEP_BYTE_BITS);
    assign ack_end = scl_fall & active & (bit_q == `TWEP_ACK_SLOT);
    assign bit_fall = scl_fall & (st_q == TWEP_RD) & (bit_q != '0) &
                      (bit_q < `TWEP_BYTE_BITS);
    // address match needs the straps and a quiet array
    assign dev_hit = (rx_q[7:1] == {`TWEP_DEV_CODE, strap}) & !busy;
    assign wr_take = byte_end & (st_q == TWEP_WR) & in_ready;
    assign launch = (start | stop) & pend_q & !busy;
    // counter wraps inside the page, never into the next one
    assign addr_page_inc = {addr_q[AW-1:PB], addr_q[PB-1:0] + 1'b1};

    // byte decision at the eighth falling edge
    always_comb begin
        nxt_sel = TWEP_IGN;
        ack_sel = 1'b0;
        case (st_q)
            TWEP_DEV: begin
                ack_sel = dev_hit;
                if (dev_hit) begin
                    nxt_sel = rx_q[`TWEP_RW_BIT] ? TWEP_RD : TWEP_AHI;
                end
            end
            TWEP_AHI: begin
                ack_sel = 1'b1;
                nxt_sel = TWEP_ALO;
            end
            TWEP_ALO: begin
                ack_sel = 1'b1;
                nxt_sel = TWEP_WR;
            end
            TWEP_WR: begin
                // a full buffer refuses the byte, ending the page
                ack_sel = in_ready;
                nxt_sel = in_ready ? TWEP_WR : TWEP_IGN;
            end
            TWEP_RD: begin
                nxt_sel = TWEP_RD;
            end
            default: begin
                nxt_sel = TWEP_IGN;
            end
        endcase
    end

    // framing and state walk
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_q <= TWEP_IDLE;
            nxt_q <= TWEP_IDLE;
        end else if (start) begin
            st_q <= TWEP_DEV;
        end else if (stop) begin
            st_q <= TWEP_IDLE;
        end else if (byte_end) begin
            nxt_q <= nxt_sel;
        end else if (ack_end) begin
            st_q <= nxt_q;
        end else if (scl_rise & active & (bit_q == `TWEP_BYTE_BITS)) begin
            // controller's no-acknowledge ends a read stream
            if ((st_q == TWEP_RD) & sda_f) begin
                nxt_q <= TWEP_IGN;
            end
        end
    end

    // bit counter and receive shift, sampled on rising clock
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bit_q <= '0;
            rx_q <= '0;
        end else if (start | ack_end) begin
            bit_q <= '0;
        end else if (scl_rise & active) begin
            if (bit_q < `TWEP_BYTE_BITS) begin
                rx_q <= {rx_q[6:0], sda_f};
            end
            bit_q <= bit_q + 1'b1;
        end
    end

    // ======================================================
    // open-drain data driver: pull low or let go
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            oe_q <= 1'b0;
        end else if (start | stop) begin
            oe_q <= 1'b0;
        end else if (byte_end) begin
            oe_q <= (st_q != TWEP_RD) & ack_sel;
        end else if (ack_end) begin
            oe_q <= (nxt_q == TWEP_RD) & !rdata[7];
        end else if (bit_fall) begin
            oe_q <= !tx_q[6];
        end
    end

    // read shifter, reloaded after each acknowledged byte
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tx_q <= '0;
        end else if (ack_end & (nxt_q == TWEP_RD)) begin
            tx_q <= rdata;
        end else if (bit_fall) begin
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end

    // ======================================================
    // address counter shared by reads and writes
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            addr_q <= '0;
            ahi_q <= '0;
            base_q <= '0;
        end else if (byte_end & (st_q == TWEP_AHI)) begin
            ahi_q <= rx_q[6:0];
        end else if (byte_end & (st_q == TWEP_ALO)) begin
            addr_q <= {ahi_q, rx_q};
            base_q <= {ahi_q, rx_q};
        end else if (wr_take) begin
            addr_q <= addr_page_inc;
        end else if (ack_end & (nxt_q == TWEP_RD)) begin
            // reads run on through the whole array
            addr_q <= addr_q + 1'b1;
        end
    end

    // ======================================================
    // bytes pair up into buffer words; a lone last byte is flushed
    assign flush = launch & stage_v_q;
    assign push = (wr_take & stage_v_q) | flush;
    assign in_data = flush ? {1'b0, 8'h00, stage_q} : {1'b1, rx_q, stage_q};

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            stage_q <= '0;
            stage_v_q <= 1'b0;
            pend_q <= 1'b0;
        end else if (launch) begin
            stage_v_q <= 1'b0;
            pend_q <= 1'b0;
        end else if (wr_take) begin
            stage_q <= rx_q;
            stage_v_q <= !stage_v_q;
            pend_q <= 1'b1;
        end
    end

    // ======================================================
    // self-timed programming cycle
    logic [AW-1:0] paddr_q;
    logic [WCW-1:0] wcnt_q;
    logic half_q;
    logic commit_q;
    logic busy_q;
    wire logic out_valid;
    wire logic out_ready;
    wire logic [`TWEP_FIFO_BITS-1:0] out_data;
    wire logic draining;
    wire logic mem_we;
    wire logic [7:0] wdata;

    assign draining = pst_q == TWEP_P_DRAIN;
    // a paired word writes its low byte first, then its high byte
    assign out_ready = draining & (half_q | !out_data[`TWEP_PAIR_BIT]);
    assign wdata = half_q ? out_data[15:8] : out_data[7:0];
    // the lock is checked at every byte, not only at the stop
    assign mem_we = clk_en & draining & out_valid & commit_q & !lock;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pst_q <= TWEP_P_IDLE;
        end else if (clk_en) begin
            case (pst_q)
                TWEP_P_IDLE: begin
                    if (launch) begin
                        pst_q <= TWEP_P_DRAIN;
                    end
                end
                TWEP_P_DRAIN: begin
                    if (!out_valid) begin
                        pst_q <= commit_q ? TWEP_P_WAIT : TWEP_P_IDLE;
                    end
                end
                TWEP_P_WAIT: begin
                    if (wcnt_q >= WR_LAST) begin
                        pst_q <= TWEP_P_IDLE;
                    end
                end
                default: begin
                    pst_q <= TWEP_P_IDLE;
                end
            endcase
        end
    end

    // a cycle aborted by a restart or locked out skips the wait
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            commit_q <= 1'b0;
            paddr_q <= '0;
            half_q <= 1'b0;
            wcnt_q <= '0;
        end else if (clk_en) begin
            if (launch) begin
                commit_q <= stop & !lock;
                paddr_q <= base_q;
                half_q <= 1'b0;
                wcnt_q <= '0;
            end else if (busy) begin
                wcnt_q <= wcnt_q + 1'b1;
                if (draining & out_valid) begin
                    half_q <= !half_q & out_data[`TWEP_PAIR_BIT];
                    paddr_q <= {paddr_q[AW-1:PB], paddr_q[PB-1:0] + 1'b1};
                end
            end
        end
    end

    // outputs straight from flops; the data level is always low
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            busy_q <= 1'b0;
        end else if (clk_en) begin
            busy_q <= busy;
        end
    end
    assign sda_oe = oe_q;
    assign sda_o = 1'b0;
    assign write_busy = busy_q;

    // ======================================================
    // page buffer and array
    twep_fifo #(
        .W(`TWEP_FIFO_BITS),
        .DEPTH(FIFO_DEPTH)
    ) i_twep_fifo (
        .clock(clock),
        .resetn(resetn),
        .en(clk_en),
        .in_valid(push),
        .in_ready(in_ready),
        .in_data(in_data),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(out_data)
    );

    twep_mem #(
        .AW(AW),
        .DW(`TWEP_DATA_BITS)
    ) i_twep_mem (
        .clock(clock),
        .en(clk_en),
        .we(mem_we),
        .waddr(paddr_q),
        .wdata(wdata),
        .raddr(addr_q),
        .rdata(rdata)
    );
endmodule

// >>> sim/twep_ctrl_model.sv
// bus controller model driving the clock and data of the two-wire link
`timescale 1ns/1ps
module twep_ctrl_model (
    input wire logic clock,
    input wire logic line,
    output logic scl,
    output logic sda
);
    logic glitch;
    // ==========================================================
    // idle bus: both lines released high
    initial begin
        scl = 1'b1;
        sda = 1'b1;
        glitch = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge clock);
    endtask
    // one bit cell of 16 clocks, 17 with glitch set; data moves only while the clock is low
    task automatic xbit(input logic b, output logic r);
        wt(4);
        sda = b;
        wt(4);
        scl = 1'b1;
        wt(2);
        if (glitch) begin
            scl = 1'b0; // one clock low, well under the filter length
            wt(1);
            scl = 1'b1;
        end
        wt(2);
        r = line;
        wt(4);
        scl = 1'b0;
    endtask
    // start, also usable as repeated start from a low clock
    task automatic start;
        wt(4);
        sda = 1'b1;
        wt(4);
        scl = 1'b1;
        wt(8);
        sda = 1'b0;
        wt(8);
        scl = 1'b0;
    endtask
    // stop leaves the clock high for the idle bus
    task automatic stop;
        wt(4);
        sda = 1'b0;
        wt(4);
        scl = 1'b1;
        wt(8);
        sda = 1'b1;
        wt(16);
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xbit(d[i], r);
        end
        xbit(1'b1, r);
        ack = ~r;
    endtask
    // more high asks for another byte, low ends the read
    task automatic rbyte(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xbit(1'b1, r);
            d[i] = r;
        end
        xbit(~more, r);
    endtask
endmodule

// >>> sim/twep_slave_asserts.sv
// port assertions of the two-wire eeprom slave port
`timescale 1ns/1ps
module twep_slave_asserts #(
    parameter int WR_CYC = 200
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic scl,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic write_lock,
    input wire logic write_busy
);
    logic [31:0] busy_cnt_q, busy_cnt_d;
    logic [3:0] lock_cnt_q, lock_cnt_d;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);
    // ==========================================================
    // helper counts: busy length, and how long the lock has stood high
    assign busy_cnt_d = write_busy ? busy_cnt_q + 32'h1 : 32'h0;
    assign lock_cnt_d = write_lock ? lock_cnt_q + {3'h0, lock_cnt_q != 4'hf} : 4'h0;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            busy_cnt_q <= 32'h0;
            lock_cnt_q <= 4'h0;
        end else begin
            busy_cnt_q <= busy_cnt_d;
            lock_cnt_q <= lock_cnt_d;
        end
    end
    // ==========================================================
    // data line and programming cycle
    open_drain_a: assert property (sda_o == 1'b0) else $error("data driven high");
    oe_low_phase_a:
        assert property ($changed(sda_oe) |-> !scl) else $error("data moved, clock high");
    oe_stand_a:
        assert property ($rose(scl) |=> $stable(sda_oe)[*6]) else $error("data moved early");
    busy_quiet_a: assert property (write_busy |-> !sda_oe) else $error("acked while busy");
    busy_bound_a:
        assert property (busy_cnt_q <= WR_CYC + 100) else $error("write cycle too long");
    busy_min_a:
        assert property ($fell(write_busy) |-> (busy_cnt_q >= WR_CYC - 4) || write_lock)
            else $error("cycle short");
    busy_after_stop_a:
        assert property ($rose(write_busy) |-> scl && sda_i) else $error("busy without stop");
    lock_blocks_a:
        assert property ($rose(write_busy) && lock_cnt_q == 4'hf |-> ##[1:70] !write_busy)
            else $error("locked write");
    ack_seen_c: cover property ($rose(sda_oe));
    prog_done_c: cover property ($fell(write_busy));
    locked_ack_c: cover property (lock_cnt_q == 4'hf && $rose(sda_oe));
endmodule

bind twep_slave twep_slave_asserts #(.WR_CYC(WR_CYC)) i_twep_slave_asserts (
    .clock(clock), .resetn(resetn), .scl(scl), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe(sda_oe), .write_lock(write_lock), .write_busy(write_busy));

// >>> sim/twep_slave_test.sv
// self-checking bench of the two-wire eeprom slave port
`timescale 1ns/1ps
`include "twep_defs.svh"
module twep_slave_test;
    localparam int WR = 400;
    logic clock, resetn, write_lock, scl, sda_m, sda_i, sda_o, sda_oe, write_busy, oe_seen;
    logic [2:0] strap;
    logic [7:0] img [int];
    int err_count, total_checks;
    // ==========================================================
    // wired-and data line with pull-up
    assign sda_i = sda_m & ~sda_oe;
    always #2 clock = ~clock;
    always @(posedge clock) begin
        if (sda_oe === 1'b1) oe_seen <= 1'b1;
    end
    twep_slave #(.FILT_CYC(3), .WR_CYC(WR)) i_twep_slave (
        .clock(clock), .resetn(resetn), .clk_en(1'b1), .scl(scl), .sda_i(sda_i),
        .sda_o(sda_o), .sda_oe(sda_oe), .select_strap_bit0(strap[0]),
        .select_strap_bit1(strap[1]), .select_strap_bit2(strap[2]),
        .write_lock(write_lock), .write_busy(write_busy));
    twep_ctrl_model i_twep_ctrl_model (.clock(clock), .line(sda_i), .scl(scl), .sda(sda_m));
    // ==========================================================
    // checking and reporting
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        chk_byte({7'h0, got}, {7'h0, exp});
    endtask
    task automatic results;
        $display("checks=%0d errors=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // bounded wait for the programming cycle to end
    task automatic wait_done;
        int n;
        n = 0;
        while (write_busy !== 1'b0 && n < WR + 100) begin
            @(negedge clock);
            n++;
        end
        if (n >= WR + 100) begin
            err_count++;
            results();
        end
    endtask
    function automatic logic [7:0] dev(input logic rd);
        return {`TWEP_DEV_CODE, 3'b101, rd};
    endfunction
    task automatic xfer(input logic [7:0] d, input logic ack);
        logic a;
        i_twep_ctrl_model.wbyte(d, a);
        chk_flag(a, ack);
    endtask
    // start, device byte for writing and both address bytes
    task automatic addr(input logic [14:0] a);
        i_twep_ctrl_model.start();
        xfer(dev(1'b0), 1'b1);
        xfer({1'b0, a[14:8]}, 1'b1);
        xfer(a[7:0], 1'b1);
    endtask
    // data bytes v0 + 3i; the image follows the in-page wrap
    task automatic wr(input logic [14:0] a, input int n, input logic [7:0] v0);
        addr(a);
        for (int i = 0; i < n; i++) begin
            xfer(v0 + 8'(3 * i), 1'b1);
            if (!write_lock) img[{a[14:6], 6'(a[5:0] + i)}] = v0 + 8'(3 * i);
        end
        i_twep_ctrl_model.stop();
    endtask
    // random read, then n - 1 streaming bytes, wrapping at the array end
    task automatic rd(input logic [14:0] a, input int n);
        logic [7:0] d;
        logic [14:0] p;
        addr(a);
        i_twep_ctrl_model.start();
        xfer(dev(1'b1), 1'b1);
        for (int i = 0; i < n; i++) begin
            p = a + 15'(i);
            i_twep_ctrl_model.rbyte(i < n - 1, d);
            chk_byte(d, img.exists(p) ? img[p] : `TWEP_ERASED);
        end
        i_twep_ctrl_model.stop();
    endtask
    // ==========================================================
    // scenarios
    // only the matching strap answers; others never touch the line
    task automatic t_strap;
        for (int s = 0; s < 8; s++) begin
            strap = 3'(s);
            oe_seen = 1'b0;
            repeat (4) @(negedge clock);
            i_twep_ctrl_model.start();
            xfer(dev(1'b0), s == 5);
            xfer(8'h00, s == 5);
            i_twep_ctrl_model.stop();
            chk_flag(oe_seen, s == 5);
        end
        strap = 3'b101;
        wait_done();
    endtask
    // full page; a poll during programming goes unanswered
    task automatic t_page;
        wr(15'h0040, 64, 8'h11);
        i_twep_ctrl_model.start();
        xfer(dev(1'b0), 1'b0);
        i_twep_ctrl_model.stop();
        chk_flag(write_busy, 1'b1);
        wait_done();
        rd(15'h0040, 64);
    endtask
    // short page at the array top; reading wraps to address zero
    task automatic t_wrap;
        wr(15'h7ffe, 2, 8'hc4);
        wait_done();
        rd(15'h7ffd, 4);
    endtask
    // lock high: data acked, nothing stored, no wait; then glitchy reads
    task automatic t_lock;
        write_lock = 1'b1;
        wr(15'h0041, 1, 8'h00);
        repeat (20) @(negedge clock);
        chk_flag(write_busy, 1'b0);
        write_lock = 1'b0;
        i_twep_ctrl_model.glitch = 1'b1;
        rd(15'h0040, 3);
        i_twep_ctrl_model.glitch = 1'b0;
    endtask
    initial begin
        clock = 1'b0;
        resetn = 1'b0;
        write_lock = 1'b0;
        strap = 3'b101;
        oe_seen = 1'b0;
        err_count = 0;
        total_checks = 0;
        repeat (6) @(negedge clock);
        resetn = 1'b1;
        repeat (20) @(negedge clock);
        t_strap();
        t_page();
        t_wrap();
        t_lock();
        results();
    end
endmodule
